// File: rtl/scr_regs.sv
`timescale 1ns/1ns
// Operation
// RULE1: three-bit monitor select in bits 7:5, zero disables, zero at reset.
// RULE2: code 001 shorts amplifier inputs to mid-supply, user gain kept.
// RULE3: code 010 selects temperature sensor; host keeps amplifier enabled with 01.
// RULE4: code 011 analog supply over four, 100 digital supply over four.
// RULE5: codes 101, 110, 111 enable burn-out sources 0.2, 1, 10 uA.
// RULE6: supply monitors force gain one regardless of gain field.
// RULE7: mid-short, temperature and supply monitors open all input switches.
// RULE8: host keeps gain at four or below during temperature measurement.
// RULE9: bits 4:3 choose calibration averaging 1, 4, 8, 16; reset eight.
// RULE10: bit 2 enables serial timeout; cleared at reset.
// RULE11: bit 1 appends CRC over result plus status byte when enabled.
// RULE12: bit 0 sends status byte before result; cleared at reset.
// RULE13: byte at 0Ah reads zero; host writes only zero.
// RULE14: 0Bh holds offset calibration low byte, read/write, reset zero.
// RULE15: 0Ch holds offset calibration high byte, forming sixteen bits.
// RULE16: system control at 09h resets to 10h.
module scr_regs
    import scr_pkg::*;
(
    input wire logic core_clk, // 125 MHz clock
    input wire logic rst, // synchronous reset, high
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic [2:0] gain_cfg, // user gain from gain register
    input wire logic [1:0] amplifier_enable, // amplifier enable field
    output scr_pkg::scr_afe_ctl_t afe_ctl, // analog steering
    output logic [2:0] gain_eff, // effective gain code
    output scr_pkg::scr_frame_ctl_t frame_ctl, // data framing options
    output logic [15:0] offset_calibration_value, // offset calibration
    output logic temp_cfg_err // temperature set-up outside limits
);
    import scr_pkg::*;

    // ****************************************************
    // storage
    // ****************************************************
    logic [7:0] system_control_config_q;
    logic [7:0] offset_cal_low_byte_q;
    logic [7:0] offset_cal_high_byte_q;
    logic [7:0] rdata_q;
    logic [2:0] system_monitor_select;
    logic [1:0] calibration_sample_count;
    logic [4:0] cal_samples;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            system_control_config_q <= SCR_CTL_RESET; // RULE16 RULE1 RULE9 RULE10 RULE12
        end else if (reg_wr && reg_addr == SCR_CTL_ADDR) begin
            system_control_config_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            offset_cal_low_byte_q <= SCR_OFS_RESET; // RULE14
        end else if (reg_wr && reg_addr == SCR_OFS_LO_ADDR) begin
            offset_cal_low_byte_q <= reg_wdata; // RULE14
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            offset_cal_high_byte_q <= SCR_OFS_RESET;
        end else if (reg_wr && reg_addr == SCR_OFS_HI_ADDR) begin
            offset_cal_high_byte_q <= reg_wdata; // RULE15
        end
    end

    // ****************************************************
    // read port
    // ****************************************************
    // writes to the reserved byte are dropped so it always reads zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                SCR_CTL_ADDR: rdata_q <= system_control_config_q;
                SCR_RSV_ADDR: rdata_q <= SCR_RSV_VALUE; // RULE13
                SCR_OFS_LO_ADDR: rdata_q <= offset_cal_low_byte_q; // RULE14
                SCR_OFS_HI_ADDR: rdata_q <= offset_cal_high_byte_q; // RULE15
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // ****************************************************
    // field decode
    // ****************************************************
    assign system_monitor_select = system_control_config_q[SCR_MON_MSB:SCR_MON_LSB]; // RULE1
    assign calibration_sample_count = system_control_config_q[SCR_CAL_MSB:SCR_CAL_LSB]; // RULE9
    assign offset_calibration_value = {offset_cal_high_byte_q, offset_cal_low_byte_q}; // RULE15

    scr_mon_decode u_mon (
        .system_monitor_select(system_monitor_select),
        .gain_cfg(gain_cfg),
        .afe_ctl(afe_ctl),
        .gain_eff(gain_eff)
    );

    scr_cal_count u_cal (
        .calibration_sample_count(calibration_sample_count),
        .cal_samples(cal_samples)
    );

    always_comb begin
        frame_ctl.cal_samples = cal_samples; // RULE9
        frame_ctl.timeout_en = system_control_config_q[SCR_TMO_BIT]; // RULE10
        frame_ctl.crc_en = system_control_config_q[SCR_CRC_BIT]; // RULE11
        frame_ctl.status_byte_en = system_control_config_q[SCR_STAT_BIT]; // RULE12
    end

    // flags a host that breaks the temperature set-up; the block itself cannot enforce it
    assign temp_cfg_err = afe_ctl.temp_sense && (amplifier_enable != SCR_AMP_EN_ON || gain_cfg > SCR_GAIN_FOUR); // RULE3 RULE8

    // ****************************************************
    // assertions
    // ****************************************************
    sequence ctl_write_s;
        reg_wr && reg_addr == SCR_CTL_ADDR;
    endsequence

    sequence ctl_read_s;
        reg_rd && reg_addr == SCR_CTL_ADDR;
    endsequence

    ctl_reset_a: assert property (@(posedge core_clk) rst |=> system_control_config_q == 8'h10) // RULE16
        else $error("system control not 10h after reset");
    ctl_wr_rd_a: assert property (@(posedge core_clk) disable iff (rst)
        ctl_write_s ##1 (ctl_read_s and (!reg_wr)) |=> reg_rdata == $past(reg_wdata, 2)) // RULE16
        else $error("system control readback mismatch");
    mon_off_a: assert property (@(posedge core_clk) disable iff (rst)
        system_monitor_select == 3'h0 |-> afe_ctl == '0) // RULE1
        else $error("monitor active while disabled");
    mid_short_a: assert property (@(posedge core_clk) disable iff (rst)
        system_monitor_select == 3'h1 |-> afe_ctl.mid_short && afe_ctl.mux_open && gain_eff == gain_cfg) // RULE2
        else $error("mid-supply short wrong");
    temp_sel_a: assert property (@(posedge core_clk) disable iff (rst)
        system_monitor_select == 3'h2 |-> afe_ctl.temp_sense && gain_eff == gain_cfg) // RULE3
        else $error("temperature select wrong");
    supply_gain_a: assert property (@(posedge core_clk) disable iff (rst)
        (system_monitor_select == 3'h3 || system_monitor_select == 3'h4) |-> gain_eff == 3'h0 && afe_ctl.mux_open) // RULE4
        else $error("supply monitor gain not one");
    gain_force_a: assert property (@(posedge core_clk) disable iff (rst)
        afe_ctl.gain_force_one == (afe_ctl.asup_mon || afe_ctl.dsup_mon)) // RULE6
        else $error("gain override mismatch");
    burnout_a: assert property (@(posedge core_clk) disable iff (rst)
        system_monitor_select == 3'h7 |-> afe_ctl.burnout == SCR_BO_10U && !afe_ctl.mux_open) // RULE5
        else $error("burn-out setting wrong");
    mux_open_a: assert property (@(posedge core_clk) disable iff (rst)
        afe_ctl.mux_open |-> system_monitor_select inside {3'h1, 3'h2, 3'h3, 3'h4}) // RULE7
        else $error("switches opened unexpectedly");
    cal_count_a: assert property (@(posedge core_clk) disable iff (rst)
        calibration_sample_count == 2'h2 |-> frame_ctl.cal_samples == 5'h08) // RULE9
        else $error("calibration count wrong");
    temp_gain_a: assert property (@(posedge core_clk) disable iff (rst)
        (afe_ctl.temp_sense && gain_cfg >= 3'h3) |-> temp_cfg_err) // RULE8
        else $error("excess temperature gain not flagged");
    flags_a: assert property (@(posedge core_clk) disable iff (rst)
        frame_ctl.timeout_en == system_control_config_q[2] && frame_ctl.crc_en == system_control_config_q[1]
        && frame_ctl.status_byte_en == system_control_config_q[0]) // RULE10 RULE11 RULE12
        else $error("framing bits mismatch");
    rsv_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == SCR_RSV_ADDR |=> reg_rdata == 8'h00) // RULE13
        else $error("reserved byte not zero");
    ofs_low_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == SCR_OFS_LO_ADDR |=> offset_calibration_value[7:0] == $past(reg_wdata)) // RULE14
        else $error("offset low byte not stored");
    ofs_high_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == SCR_OFS_HI_ADDR |=> offset_calibration_value[15:8] == $past(reg_wdata)) // RULE15
        else $error("offset high byte not stored");
endmodule

// File: rtl/scr_pkg.sv
package scr_pkg;
    // ****************************************************
    // register map
    // ****************************************************
    localparam logic [7:0] SCR_CTL_ADDR = 8'h09;
    localparam logic [7:0] SCR_RSV_ADDR = 8'h0a;
    localparam logic [7:0] SCR_OFS_LO_ADDR = 8'h0b;
    localparam logic [7:0] SCR_OFS_HI_ADDR = 8'h0c;
    localparam logic [7:0] SCR_CTL_RESET = 8'h10;
    localparam logic [7:0] SCR_OFS_RESET = 8'h00;
    localparam logic [7:0] SCR_RSV_VALUE = 8'h00;
    // ****************************************************
    // system control fields
    // ****************************************************
    localparam int SCR_MON_MSB = 7;
    localparam int SCR_MON_LSB = 5;
    localparam int SCR_CAL_MSB = 4;
    localparam int SCR_CAL_LSB = 3;
    localparam int SCR_TMO_BIT = 2;
    localparam int SCR_CRC_BIT = 1;
    localparam int SCR_STAT_BIT = 0;
    localparam logic [2:0] SCR_MON_OFF = 3'h0;
    localparam logic [2:0] SCR_MON_MID = 3'h1;
    localparam logic [2:0] SCR_MON_TEMP = 3'h2;
    localparam logic [2:0] SCR_MON_ASUP = 3'h3;
    localparam logic [2:0] SCR_MON_DSUP = 3'h4;
    localparam logic [2:0] SCR_MON_BO02 = 3'h5;
    localparam logic [2:0] SCR_MON_BO1 = 3'h6;
    localparam logic [2:0] SCR_MON_BO10 = 3'h7;
    localparam logic [1:0] SCR_AMP_EN_ON = 2'h1;
    localparam logic [2:0] SCR_GAIN_ONE = 3'h0;
    localparam logic [2:0] SCR_GAIN_FOUR = 3'h2;

    typedef enum logic [1:0] {
        SCR_BO_OFF,
        SCR_BO_0U2,
        SCR_BO_1U,
        SCR_BO_10U
    } scr_burnout_t;

    // analog front-end steering derived from the monitor selection
    typedef struct packed {
        logic mid_short;
        logic temp_sense;
        logic asup_mon;
        logic dsup_mon;
        logic mux_open;
        logic gain_force_one;
        scr_burnout_t burnout;
    } scr_afe_ctl_t;

    // data path framing options
    typedef struct packed {
        logic [4:0] cal_samples;
        logic timeout_en;
        logic crc_en;
        logic status_byte_en;
    } scr_frame_ctl_t;
endpackage

// File: rtl/scr_mon_decode.sv
`timescale 1ns/1ns
module scr_mon_decode
    import scr_pkg::*;
(
    input wire logic [2:0] system_monitor_select, // monitor code
    input wire logic [2:0] gain_cfg, // user gain code
    output scr_pkg::scr_afe_ctl_t afe_ctl, // steering
    output logic [2:0] gain_eff // gain code actually used
);
    always_comb begin
        afe_ctl = '0;
        unique case (system_monitor_select)
            SCR_MON_OFF: afe_ctl = '0;
            SCR_MON_MID: afe_ctl.mid_short = 1'b1; // RULE2
            SCR_MON_TEMP: afe_ctl.temp_sense = 1'b1; // RULE3
            SCR_MON_ASUP: afe_ctl.asup_mon = 1'b1; // RULE4
            SCR_MON_DSUP: afe_ctl.dsup_mon = 1'b1; // RULE4
            SCR_MON_BO02: afe_ctl.burnout = SCR_BO_0U2; // RULE5
            SCR_MON_BO1: afe_ctl.burnout = SCR_BO_1U; // RULE5
            SCR_MON_BO10: afe_ctl.burnout = SCR_BO_10U; // RULE5
        endcase
        afe_ctl.mux_open = afe_ctl.mid_short | afe_ctl.temp_sense | afe_ctl.asup_mon | afe_ctl.dsup_mon; // RULE7
        afe_ctl.gain_force_one = afe_ctl.asup_mon | afe_ctl.dsup_mon; // RULE6
    end

    // supply monitors override the user gain
    assign gain_eff = afe_ctl.gain_force_one ? SCR_GAIN_ONE : gain_cfg; // RULE6
endmodule

// File: rtl/scr_cal_count.sv
`timescale 1ns/1ns
module scr_cal_count
    import scr_pkg::*;
(
    input wire logic [1:0] calibration_sample_count, // sample code
    output logic [4:0] cal_samples // samples averaged
);
    always_comb begin
        unique case (calibration_sample_count)
            2'h0: cal_samples = 5'h01; // RULE9
            2'h1: cal_samples = 5'h04;
            2'h2: cal_samples = 5'h08;
            2'h3: cal_samples = 5'h10;
        endcase
    end
endmodule

// File: sim/scr_host_model.sv
`timescale 1ns/1ns
module scr_host_model (
    input wire logic core_clk, // clock
    input wire logic [2:0] gain_req, // gain the test asks for
    input wire logic temp_sel, // temperature monitor in use
    input wire logic bend_rules, // present an illegal set-up
    output logic [2:0] gain_cfg, // gain to the block
    output logic [1:0] amplifier_enable // amplifier enable to the block
);
    import scr_pkg::*;
    initial begin
        gain_cfg = 3'h0;
        amplifier_enable = SCR_AMP_EN_ON;
    end
    // ****************************************************
    // host side of the temperature set-up
    // ****************************************************
    always @(posedge core_clk) begin
        if (temp_sel && !bend_rules) begin
            // above gain four the sensor signal leaves the amplifier range
            gain_cfg <= (gain_req > SCR_GAIN_FOUR) ? SCR_GAIN_FOUR : gain_req;
            amplifier_enable <= SCR_AMP_EN_ON;
        end else begin
            gain_cfg <= gain_req;
            amplifier_enable <= bend_rules ? 2'h2 : SCR_AMP_EN_ON;
        end
    end
endmodule

// File: sim/test_system_control_and_offset_cal_regs.sv
`timescale 1ns/1ns
module test_system_control_and_offset_cal_regs;
    import scr_pkg::*;
    logic core_clk, rst, reg_wr, reg_rd, temp_sel, bend_rules, temp_cfg_err;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [2:0] gain_req, gain_cfg, gain_eff, g;
    logic [1:0] amplifier_enable;
    logic [15:0] offset_calibration_value;
    scr_afe_ctl_t afe_ctl, afe_exp;
    scr_frame_ctl_t frame_ctl;
    logic [4:0] cal_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
    int mismatches = 0;
    int checks_done = 0;

    scr_regs dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gain_cfg(gain_cfg),
        .amplifier_enable(amplifier_enable), .afe_ctl(afe_ctl), .gain_eff(gain_eff),
        .frame_ctl(frame_ctl), .offset_calibration_value(offset_calibration_value),
        .temp_cfg_err(temp_cfg_err));
    scr_host_model host_u (.core_clk(core_clk), .gain_req(gain_req), .temp_sel(temp_sel),
        .bend_rules(bend_rules), .gain_cfg(gain_cfg), .amplifier_enable(amplifier_enable));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ****************************************************
    // bus tasks and comparison
    // ****************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        rst <= 1'b1;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= 8'h00;
        reg_wdata <= 8'h00;
        temp_sel <= 1'b0;
        bend_rules <= 1'b0;
        gain_req <= 3'h5;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check({8'h00, frame_ctl}, {8'h00, 5'h08, 3'h0});
        check({8'h00, afe_ctl}, 16'h0000);
        check(offset_calibration_value, 16'h0000);
        rd(SCR_CTL_ADDR, SCR_CTL_RESET);
        rd(SCR_RSV_ADDR, 8'h00);
        rd(SCR_OFS_LO_ADDR, 8'h00);
        rd(SCR_OFS_HI_ADDR, 8'h00);
        // every monitor code, with each calibration and framing pattern along the way
        for (int i = 0; i < 8; i++) begin
            v = {i[2:0], i[1:0], i[2:0]};
            temp_sel <= (i == 2);
            wr(SCR_CTL_ADDR, v);
            afe_exp = '0;
            afe_exp.mid_short = (i == 1);
            afe_exp.temp_sense = (i == 2);
            afe_exp.asup_mon = (i == 3);
            afe_exp.dsup_mon = (i == 4);
            afe_exp.mux_open = (i >= 1 && i <= 4);
            afe_exp.gain_force_one = (i == 3 || i == 4);
            afe_exp.burnout = scr_burnout_t'((i >= 5) ? i[1:0] : 2'h0);
            g = (i == 3 || i == 4) ? SCR_GAIN_ONE : ((i == 2) ? SCR_GAIN_FOUR : 3'h5);
            check({8'h00, afe_ctl}, {8'h00, afe_exp});
            check({13'h0000, gain_eff}, {13'h0000, g});
            check({8'h00, frame_ctl}, {8'h00, cal_tab[i % 4], v[2], v[1], v[0]});
            rd(SCR_CTL_ADDR, v);
        end
        // temperature set-up kept legal by the host, then broken on purpose
        temp_sel <= 1'b1;
        gain_req <= 3'h7;
        wr(SCR_CTL_ADDR, 8'h50);
        @(posedge core_clk);
        #1;
        check({15'h0000, temp_cfg_err}, 16'h0000);
        check({13'h0000, gain_eff}, {13'h0000, SCR_GAIN_FOUR});
        bend_rules <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        check({15'h0000, temp_cfg_err}, 16'h0001);
        bend_rules <= 1'b0;
        temp_sel <= 1'b0;
        gain_req <= 3'h5;
        wr(SCR_OFS_LO_ADDR, 8'ha5);
        wr(SCR_OFS_HI_ADDR, 8'h3c);
        // the host may only ever write zero to the reserved byte
        wr(SCR_RSV_ADDR, 8'h00);
        check(offset_calibration_value, 16'h3ca5);
        rd(SCR_OFS_LO_ADDR, 8'ha5);
        @(posedge core_clk);
        #1;
        check({8'h00, reg_rdata}, 16'h0000);
        rd(SCR_OFS_HI_ADDR, 8'h3c);
        rd(SCR_RSV_ADDR, 8'h00);
        rd(8'h20, 8'h00);
        wr(SCR_OFS_LO_ADDR, 8'h5a);
        check(offset_calibration_value, 16'h3c5a);
        // write then read back with no idle cycle between the strobes
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= SCR_CTL_ADDR;
        reg_wdata <= 8'h0d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check({8'h00, reg_rdata}, 16'h000d);
        check({8'h00, frame_ctl}, {8'h00, 5'h04, 3'h5});
        // reset again in mid-run
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check(offset_calibration_value, 16'h0000);
        rd(SCR_CTL_ADDR, SCR_CTL_RESET);
        give_verdict();
    end
endmodule
